/* testbench/protection_stage_trip_timer_bench.sv */
`timescale 1ns/100ps
module protection_stage_trip_timer_bench;
	localparam int CYC = 200;
	localparam int LIMIT = 40000;
	logic ref_clk_i, reset_n_i, rd, wr, ld, blk_want, blk_in;
	logic wait_o, start, trip, blocked, disp_ev, blk_ev, blk_over, ev_over;
	logic [7:0] adr;
	logic [3:0] be;
	logic [31:0] wdat, q, rdata;
	logic [15:0] v_want, volt, blk_volt, ev_volt;
	int err_total, n_compared, phase, clocks, n_ev, n_disp;

	ptt_trip_timer #(.CYCLE_CLKS(CYC), .VW(16)) dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.measured_voltage_i(volt), .blocking_i(blk_in), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_o), .start_o(start), .trip_o(trip), .blocked_o(blocked),
		.disp_event_o(disp_ev), .blk_event_o(blk_ev), .blk_voltage_o(blk_volt), .blk_over_o(blk_over));

	ptt_far_side far (.ref_clk_i(ref_clk_i), .load_i(ld), .level_i(v_want), .block_i(blk_want),
		.measured_voltage_o(volt), .blocking_o(blk_in));

	// Free-running 250 MHz clock.
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	// Phase within the 200-clock cycle, hang guard and event capture.
	always @(posedge ref_clk_i) begin
		phase <= reset_n_i ? (phase + 1) % CYC : 0;
		clocks <= clocks + 1;
		if (blk_ev === 1'b1) begin
			n_ev <= n_ev + 1;
			ev_volt <= blk_volt;
			ev_over <= blk_over;
		end
		if (disp_ev === 1'b1) n_disp <= n_disp + 1;
		if (clocks == LIMIT) begin
			err_total++;
			$display("Error run expected finish seen hang");
			give_verdict();
		end
	end

	task automatic give_verdict;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict

	task automatic check_bit(input string name, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %b seen %b", name, exp, got);
		end
	endtask : check_bit

	task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : check_word

	// One bus transfer; entered just after a rising edge, request held until waitrequest is low.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		do @(posedge ref_clk_i); while (wait_o !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge ref_clk_i);
	endtask : bus

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
		bus(1'b0, a, 32'h0000_0000);
		check_word(name, exp, q);
	endtask : rd_chk

	task automatic wait_phase(input int p);
		while (phase != p) @(posedge ref_clk_i);
	endtask : wait_phase

	// Loads the far side off the tick edge and returns once the next tick's evaluation has settled.
	task automatic cyc(input logic [15:0] v, input logic b);
		if (phase == 0) @(posedge ref_clk_i);
		v_want <= v;
		blk_want <= b;
		ld <= 1'b1;
		@(posedge ref_clk_i);
		ld <= 1'b0;
		wait_phase(0);
		wait_phase(150);
	endtask : cyc

	task automatic outs(input logic s, input logic t, input logic bl);
		check_bit("start", s, start);
		check_bit("trip", t, trip);
		check_bit("blocked", bl, blocked);
	endtask : outs

	task automatic idle(input int n);
		repeat (n) cyc(16'h0000, 1'b0);
	endtask : idle

	// Pick twice, pause, pick three times and look at the trip on the last pick.
	task automatic hold_seq(input logic [31:0] ctrl, input logic exp, input int gap);
		bus(1'b1, ptt_pkg::OFS_CTRL, ctrl);
		repeat (2) cyc(16'h04b0, 1'b0);
		idle(gap);
		repeat (3) cyc(16'h04b0, 1'b0);
		check_bit("resume trip", exp, trip);
		idle(6);
	endtask : hold_seq

	initial begin
		int d;
		logic [31:0] r;
		reset_n_i = 1'b0;
		adr = 8'h00;
		rd = 1'b0;
		wr = 1'b0;
		wdat = 32'h0000_0000;
		be = 4'hf;
		ld = 1'b0;
		v_want = 16'h0000;
		blk_want = 1'b0;
		{err_total, n_compared, phase, clocks, n_ev, n_disp} = '0;
		void'($urandom(49825));
		repeat (3) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		rd_chk(ptt_pkg::OFS_CTRL, 32'h0000_0169, "ctrl");
		rd_chk(ptt_pkg::OFS_LEVEL, 32'h0000_0069, "level");
		rd_chk(ptt_pkg::OFS_DTDLY, 32'h0000_0008, "fixed delay");
		rd_chk(ptt_pkg::OFS_KDIAL, 32'h0000_0005, "dial");
		rd_chk(ptt_pkg::OFS_EXPO, 32'h0000_0064, "exponent");
		rd_chk(ptt_pkg::OFS_RELDLY, 32'h0000_000c, "release delay");
		rd_chk(8'h28, 32'h0000_0000, "unmapped");
		bus(1'b1, ptt_pkg::OFS_STAT, 32'hffff_ffff);
		rd_chk(ptt_pkg::OFS_STAT, 32'h0000_0000, "status");
		r = $urandom;
		bus(1'b1, ptt_pkg::OFS_LEVEL, r);
		rd_chk(ptt_pkg::OFS_LEVEL, {16'h0000, r[15:0]}, "level");
		bus(1'b1, ptt_pkg::OFS_LEVEL, 32'h0000_03e8);
		$display("test registers done");
		d = 1 + $urandom % 5;
		bus(1'b1, ptt_pkg::OFS_CTRL, 32'h0000_0155);
		bus(1'b1, ptt_pkg::OFS_DTDLY, 32'(d));
		for (int k = 1; k <= d + 2; k++) begin
			cyc(16'h03e9 + 16'($urandom % 2000), 1'b0);
			outs(1'b1, k - 1 >= d, 1'b0);
		end
		cyc(16'h03d4, 1'b0);
		check_bit("hysteresis hold", 1'b1, start);
		cyc(16'h0384, 1'b0);
		check_bit("release at once", 1'b0, start);
		idle(2);
		bus(1'b1, ptt_pkg::OFS_DTDLY, 32'h0000_0000);
		cyc(16'h04b0, 1'b0);
		outs(1'b1, 1'b1, 1'b0);
		idle(2);
		$display("test fixed and instant done");
		bus(1'b1, ptt_pkg::OFS_CTRL, 32'h0000_0159);
		bus(1'b1, ptt_pkg::OFS_RELDLY, 32'h0000_0003);
		bus(1'b1, ptt_pkg::OFS_DTDLY, 32'h0000_0032);
		cyc(16'h04b0, 1'b0);
		idle(1);
		check_bit("release hold", 1'b1, start);
		idle(3);
		check_bit("release end", 1'b0, start);
		idle(2);
		bus(1'b1, ptt_pkg::OFS_DTDLY, 32'h0000_0004);
		hold_seq(32'h0000_0165, 1'b1, 1);
		hold_seq(32'h0000_0165, 1'b0, 5);
		hold_seq(32'h0000_0155, 1'b0, 1);
		bus(1'b1, ptt_pkg::OFS_RELDLY, 32'h0000_0006);
		bus(1'b1, ptt_pkg::OFS_CTRL, 32'h0000_01a5);
		repeat (2) cyc(16'h04b0, 1'b0);
		repeat (3) begin
			idle(1);
			check_bit("counting release", 1'b0, trip);
		end
		cyc(16'h04b0, 1'b0);
		check_bit("counting trip", 1'b1, trip);
		idle(8);
		$display("test release options done");
		bus(1'b1, ptt_pkg::OFS_CTRL, 32'h0000_0155);
		cyc(16'h05dc, 1'b1);
		outs(1'b0, 1'b0, 1'b1);
		repeat (2) cyc(16'h05dc, 1'b1);
		outs(1'b0, 1'b0, 1'b1);
		check_word("block events", 32'h0000_0001, 32'(n_ev));
		check_word("display events", 32'h0000_0001, 32'(n_disp));
		check_word("event voltage", 32'h0000_05dc, {16'h0000, ev_volt});
		check_bit("event over", 1'b1, ev_over);
		idle(2);
		cyc(16'h05dc, 1'b0);
		check_bit("start before block", 1'b1, start);
		cyc(16'h05dc, 1'b1);
		outs(1'b0, 1'b0, 1'b1);
		idle(8);
		bus(1'b1, ptt_pkg::OFS_CTRL, 32'h0000_0055);
		cyc(16'h0384, 1'b0);
		check_bit("under pick", 1'b1, start);
		cyc(16'h03fc, 1'b0);
		check_bit("under hold", 1'b1, start);
		cyc(16'h0410, 1'b0);
		check_bit("under release", 1'b0, start);
		cyc(16'h0384, 1'b1);
		check_bit("event under", 1'b0, ev_over);
		bus(1'b1, ptt_pkg::OFS_CTRL, 32'h0000_0155);
		idle(2);
		$display("test blocking done");
		bus(1'b1, ptt_pkg::OFS_CTRL, 32'h0000_0156);
		repeat (3) cyc(16'h05dc, 1'b0);
		rd_chk(ptt_pkg::OFS_RATIO, 32'h0000_0096, "ratio");
		rd_chk(ptt_pkg::OFS_EXPECT, 32'h0000_0014, "expected");
		rd_chk(ptt_pkg::OFS_REMAIN, 32'h0000_0011, "remaining");
		cyc(16'h07d0, 1'b0);
		rd_chk(ptt_pkg::OFS_EXPECT, 32'h0000_000a, "expected");
		repeat (6) cyc(16'h07d0, 1'b0);
		check_bit("inverse early", 1'b0, trip);
		cyc(16'h07d0, 1'b0);
		check_bit("inverse trip", 1'b1, trip);
		idle(2);
		$display("test inverse done");
		give_verdict();
	end
endmodule : protection_stage_trip_timer_bench

/* testbench/ptt_far_side.sv */
`timescale 1ns/100ps
module ptt_far_side (
	input wire logic ref_clk_i,
	input wire logic load_i,
	input wire logic [15:0] level_i,
	input wire logic block_i,
	output logic [15:0] measured_voltage_o,
	output logic blocking_o
);
	// Comparator and blocking matrix start quiet, so the stage sees no pick-up at power-up.
	initial begin
		measured_voltage_o = 16'h0000;
		blocking_o = 1'b0;
	end

	// New values are only loaded mid-cycle, less than a cycle ahead of the tick that judges them.
	// blocking lead time
	always @(posedge ref_clk_i) begin
		if (load_i) begin
			measured_voltage_o <= level_i;
			blocking_o <= block_i;
		end
	end
endmodule : ptt_far_side

/* verilog/ptt_pkg.sv */
package ptt_pkg;
	// Clock and processing cycle timing.
	localparam int CLK_HZ = 250_000_000;
	localparam int CYCLE_MS = 5;
	localparam int CYCLE_CLKS = CLK_HZ / 1000 * CYCLE_MS;
	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_LEVEL = 8'h04;
	localparam logic [7:0] OFS_DTDLY = 8'h08;
	localparam logic [7:0] OFS_KDIAL = 8'h0c;
	localparam logic [7:0] OFS_EXPO = 8'h10;
	localparam logic [7:0] OFS_RELDLY = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;
	localparam logic [7:0] OFS_EXPECT = 8'h1c;
	localparam logic [7:0] OFS_REMAIN = 8'h20;
	localparam logic [7:0] OFS_RATIO = 8'h24;
	// Control field positions; selectors are two bits wide.
	localparam int F_DTYPE = 0;
	localparam int F_RELSEL = 2;
	localparam int F_RSTSEL = 4;
	localparam int F_CONTSEL = 6;
	localparam int F_OVER = 8;
	// Selector codes.
	localparam logic [1:0] SEL_NO = 2'h1;
	localparam logic [1:0] SEL_YES = 2'h2;
	localparam logic [1:0] FIXED_DELAY_MODE = 2'h1;
	localparam logic [1:0] INVERSE_DELAY_MODE = 2'h2;
	// Reset values; delays are in 5 ms steps, dial and exponent in 0.01.
	localparam logic [31:0] RST_CTRL = 32'h0000_0169;
	localparam logic [15:0] RST_LEVEL = 16'h0069;
	localparam logic [31:0] RST_DTDLY = 32'h0000_0008;
	localparam logic [31:0] RST_KDIAL = 32'h0000_0005;
	localparam logic [31:0] RST_EXPO = 32'h0000_0064;
	localparam logic [31:0] RST_RELDLY = 32'h0000_000c;
	// Hysteresis in percent of the pick-up level.
	localparam logic [31:0] PCT_FULL = 32'h0000_0064;
	localparam logic [31:0] PCT_OVER_REL = 32'h0000_0061;
	localparam logic [31:0] PCT_UNDER_REL = 32'h0000_0067;
	// Fixed point: ratio in Q10; longest delay 1800 s in steps.
	localparam logic [31:0] Q_ONE = 32'h0000_0400;
	localparam logic [31:0] MAX_STEPS = 32'h0005_7e40;
	localparam logic [31:0] P_CAP = 32'h4000_0000;
	localparam logic [31:0] STEPS_PER_S2 = 32'h0000_0800;
	typedef enum logic [2:0] {
		ST_IDLE, ST_RATIO, ST_POW, ST_FRAC, ST_TIME, ST_EVAL
	} ptt_state_t;
endpackage : ptt_pkg

/* verilog/ptt_trip_timer.sv */
// What this block does
// - Blocking input sampled at cycle start, before pick-up is judged.
// - Pick-up without blocking raises START and starts the trip delay.
// - Pick-up with blocking raises BLOCKED; no start or trip follows.
// - Blocking during START clears START and runs the release timing.
// - Blocking emits display and blocking events with voltage and fault type.
// - Instant mode gives TRIP together with START.
// - Fixed delay mode trips after the set delay while pick-up holds.
// - Inverse mode delay is k over the ratio power minus one, or reversed.
// - Delay type codes: fixed is 1, inverse is 2, fixed by default.
// - Fixed delay in 5 ms steps, default 40 ms, zero acts instant.
// - Dial k in 0.01 s, default 0.05 s, inverse mode only.
// - Exponent raises the ratio, default 1.00, inverse mode only.
// - Release delay in 5 ms steps, default 60 ms, holds START.
// - Delayed release on clears START after delay; off clears at once.
// - Counter reset after release clears only after a quiet release delay.
// - Continue option keeps the operating counter running during release, only with counter reset after release on.
// - While counting during release, no TRIP unless pick-up returns.
// - Remaining time to trip readable in 5 ms steps.
// - Expected time readable, recomputed each cycle in inverse mode.
// - Measured to pick-up ratio readable in 0.01 steps.
// - Pick-up hysteresis: over releases at 97 %, under at 103 %.
// - START only while blocking is inactive.
`timescale 1ns/100ps
module ptt_trip_timer #(
	parameter int CYCLE_CLKS = ptt_pkg::CYCLE_CLKS,
	parameter int VW = 16
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic [VW-1:0] measured_voltage_i,
	input wire logic blocking_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic start_o,
	output logic trip_o,
	output logic blocked_o,
	output logic disp_event_o,
	output logic blk_event_o,
	output logic [VW-1:0] blk_voltage_o,
	output logic blk_over_o
);
	// Refuse a cycle too short for the sequential calculation.
	if (CYCLE_CLKS < 128 || VW < 8 || VW > 16) begin : g_chk
		$error("ptt_trip_timer: unsupported parameter values");
	end

	// Apply byte enables to a register write.
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

	// Saturating one-step increment of a counter.
	function automatic logic [31:0] inc_sat(input logic [31:0] v);
		return (v == 32'hffff_ffff) ? v : v + 32'h1;
	endfunction : inc_sat

	// Reset release through two flip-flops.
	logic [1:0] rst_sync_reg;
	wire rst_n = rst_sync_reg[1];
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) rst_sync_reg <= 2'h0;
		else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end

	// Processing cycle divider gives one tick every 5 ms.
	logic [31:0] div_cnt_reg;
	wire tick = (div_cnt_reg == 32'(CYCLE_CLKS - 1));
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) div_cnt_reg <= 32'h0;
		else div_cnt_reg <= tick ? 32'h0 : div_cnt_reg + 32'h1;
	end

	// Software registers.
	logic [31:0] ctrl_reg, dtdly_reg, kdial_reg, expo_reg, reldly_reg;
	logic [15:0] level_reg;
	wire [1:0] dtype = ctrl_reg[ptt_pkg::F_DTYPE +: 2];
	wire rel_on = ctrl_reg[ptt_pkg::F_RELSEL +: 2] == ptt_pkg::SEL_YES;
	wire rst_on = ctrl_reg[ptt_pkg::F_RSTSEL +: 2] == ptt_pkg::SEL_YES;
	wire cont_on = ctrl_reg[ptt_pkg::F_CONTSEL +: 2] == ptt_pkg::SEL_YES;
	wire over = ctrl_reg[ptt_pkg::F_OVER];
	wire inv_mode = dtype == ptt_pkg::INVERSE_DELAY_MODE;

	// Bus handshake: every access answers one cycle after it appears.
	logic resp_reg;
	wire req = avs_read_i | avs_write_i;
	wire take = req & ~resp_reg;
	wire wr_take = avs_write_i & take;
	assign avs_waitrequest_o = req & ~resp_reg;

	// Write port: the write lands on the edge where waitrequest is low.
	wire wr_go = avs_write_i & resp_reg;
	wire [31:0] wd = avs_writedata_i;
	wire [3:0] be = avs_byteenable_i;
	wire [31:0] lvl_ext = {16'h0, level_reg};
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= ptt_pkg::RST_CTRL;
			level_reg <= ptt_pkg::RST_LEVEL;
			dtdly_reg <= ptt_pkg::RST_DTDLY;
			kdial_reg <= ptt_pkg::RST_KDIAL;
			expo_reg <= ptt_pkg::RST_EXPO;
			reldly_reg <= ptt_pkg::RST_RELDLY;
		end else if (wr_go) begin
			case (avs_address_i)
				ptt_pkg::OFS_CTRL: ctrl_reg <= be_merge(ctrl_reg, wd, be);
				ptt_pkg::OFS_LEVEL: level_reg <= 16'(be_merge(lvl_ext, wd, be));
				ptt_pkg::OFS_DTDLY: dtdly_reg <= be_merge(dtdly_reg, wd, be);
				ptt_pkg::OFS_KDIAL: kdial_reg <= be_merge(kdial_reg, wd, be);
				ptt_pkg::OFS_EXPO: expo_reg <= be_merge(expo_reg, wd, be);
				ptt_pkg::OFS_RELDLY: reldly_reg <= be_merge(reldly_reg, wd, be);
				default: ;
			endcase
		end
	end

	// Status and information registers, written at evaluation; the expected time one clock before.
	logic start_reg, trip_reg, blocked_reg, pick_reg, rel_reg;
	logic [31:0] opc_reg, relc_reg, expect_reg, remain_reg, ratio_reg;
	wire [31:0] stat = {27'h0, rel_reg, pick_reg, blocked_reg, trip_reg, start_reg};

	// Read multiplexer; unmapped offsets read as zero.
	logic [31:0] rd_mux;
	always_comb begin
		case (avs_address_i)
			ptt_pkg::OFS_CTRL: rd_mux = ctrl_reg;
			ptt_pkg::OFS_LEVEL: rd_mux = lvl_ext;
			ptt_pkg::OFS_DTDLY: rd_mux = dtdly_reg;
			ptt_pkg::OFS_KDIAL: rd_mux = kdial_reg;
			ptt_pkg::OFS_EXPO: rd_mux = expo_reg;
			ptt_pkg::OFS_RELDLY: rd_mux = reldly_reg;
			ptt_pkg::OFS_STAT: rd_mux = stat;
			ptt_pkg::OFS_EXPECT: rd_mux = expect_reg;
			ptt_pkg::OFS_REMAIN: rd_mux = remain_reg;
			ptt_pkg::OFS_RATIO: rd_mux = ratio_reg;
			default: rd_mux = 32'h0;
		endcase
	end

	// Answer flag and registered read data.
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			resp_reg <= 1'b0;
			avs_readdata_o <= 32'h0;
		end else begin
			resp_reg <= take & ~wr_take | wr_take;
			if (take) avs_readdata_o <= rd_mux;
		end
	end

	// Shared restoring divider, one quotient bit per clock.
	logic [31:0] dnum_reg, dden_reg, dq_reg, dr_reg;
	logic [5:0] dcnt_reg;
	wire [32:0] d_shift = {dr_reg, dnum_reg[31]};
	wire d_ge = d_shift >= {1'b0, dden_reg};
	wire [32:0] d_sub = d_shift - {1'b0, dden_reg};
	wire [31:0] d_rem = d_ge ? d_sub[31:0] : d_shift[31:0];
	wire [31:0] d_quo = {dq_reg[30:0], d_ge};
	wire d_last = dcnt_reg == 6'h1f;

	// Calculation sequence state.
	ptt_pkg::ptt_state_t st_reg;
	logic blk_s_reg;
	logic [15:0] um_reg;
	logic [31:0] rq_reg, pw_reg;
	logic [4:0] pn_reg;

	// Power step in Q10, saturated to keep the product in range.
	wire [63:0] pw_mul = 64'(pw_reg) * 64'(rq_reg);
	wire [63:0] pw_sh = pw_mul >> 10;
	wire [31:0] pw_step = (pw_sh >= 64'(ptt_pkg::P_CAP)) ? ptt_pkg::P_CAP : pw_sh[31:0];
	wire [6:0] expo_frac = 7'(expo_reg % 32'd100);
	wire [4:0] expo_int = 5'(expo_reg / 32'd100);

	// Fractional exponent part by linear interpolation toward one more power.
	wire [31:0] pw_up = pw_step;
	wire signed [63:0] pw_df = 64'(signed'(pw_up - pw_reg)) * 64'(expo_frac) * 64'd1311;
	wire [31:0] pw_fr = pw_reg + 32'(pw_df >>> 17);

	// Denominator of the inverse characteristic, by term.
	// inverse formula
	wire [31:0] den_over = pw_reg - ptt_pkg::Q_ONE;
	wire [31:0] den_under = ptt_pkg::Q_ONE - pw_reg;
	wire den_ok = over ? (pw_reg > ptt_pkg::Q_ONE) : (pw_reg < ptt_pkg::Q_ONE);
	wire [31:0] t_num = ptt_pkg::STEPS_PER_S2 * kdial_reg;

	// Hysteresis comparator on the sampled voltage.
	// pick-up hysteresis
	wire [31:0] um100 = 32'(um_reg) * ptt_pkg::PCT_FULL;
	wire [31:0] us100 = lvl_ext * ptt_pkg::PCT_FULL;
	wire [31:0] us97 = lvl_ext * ptt_pkg::PCT_OVER_REL;
	wire [31:0] us103 = lvl_ext * ptt_pkg::PCT_UNDER_REL;
	wire pick_over = pick_reg ? (um100 >= us97) : (um100 > us100);
	wire pick_under = pick_reg ? (um100 <= us103) : (um100 < us100);
	wire pick_next = over ? pick_over : pick_under;
	wire eff = pick_next & ~blk_s_reg;

	// Operating delay in 5 ms steps for the selected type.
	// fixed delay
	wire [31:0] delay = inv_mode ? expect_reg : dtdly_reg;

	// Release bookkeeping.
	// release delay
	wire [31:0] relc_n = inc_sat(relc_reg);
	wire rel_done = relc_n >= reldly_reg;
	wire active = start_reg | rel_reg;

	// Next state of the timer outputs at evaluation.
	logic start_n, trip_n, rel_n;
	logic [31:0] opc_n, relcnt_n;
	always_comb begin
		start_n = 1'b0;
		trip_n = 1'b0;
		rel_n = 1'b0;
		opc_n = 32'h0;
		relcnt_n = 32'h0;
		if (eff) begin
			start_n = 1'b1;
			// instant trip, fixed trip, per-cycle step
			trip_n = opc_reg >= delay;
			opc_n = inc_sat(opc_reg);
		end else if (active) begin
			start_n = start_reg & rel_on & ~rel_done & ~blk_s_reg;
			rel_n = ~rel_done & (rel_on | rst_on);
			relcnt_n = rel_n ? relc_n : 32'h0;
			if (!rst_on || rel_done) opc_n = 32'h0;
			else if (cont_on) opc_n = inc_sat(opc_reg);
			else opc_n = opc_reg;
			trip_n = 1'b0;
		end
	end

	// Sequence: sample, ratio, power, time, evaluate.
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= ptt_pkg::ST_IDLE;
			blk_s_reg <= 1'b0;
			um_reg <= 16'h0;
			rq_reg <= 32'h0;
			pw_reg <= 32'h0;
			pn_reg <= 5'h0;
			dnum_reg <= 32'h0;
			dden_reg <= 32'h0;
			dq_reg <= 32'h0;
			dr_reg <= 32'h0;
			dcnt_reg <= 6'h0;
		end else begin
			case (st_reg)
				ptt_pkg::ST_IDLE: begin
					if (tick) begin
						blk_s_reg <= blocking_i;
						um_reg <= 16'(measured_voltage_i);
						dnum_reg <= 32'(measured_voltage_i) << 10;
						dden_reg <= (level_reg == 16'h0) ? 32'h1 : lvl_ext;
						dq_reg <= 32'h0;
						dr_reg <= 32'h0;
						dcnt_reg <= 6'h0;
						st_reg <= ptt_pkg::ST_RATIO;
					end
				end
				ptt_pkg::ST_RATIO: begin
					dnum_reg <= dnum_reg << 1;
					dr_reg <= d_rem;
					dq_reg <= d_quo;
					dcnt_reg <= dcnt_reg + 6'h1;
					if (d_last) begin
						rq_reg <= d_quo;
						pw_reg <= ptt_pkg::Q_ONE;
						pn_reg <= 5'h0;
						st_reg <= ptt_pkg::ST_POW;
					end
				end
				ptt_pkg::ST_POW: begin
					if (pn_reg < expo_int) begin
						pw_reg <= pw_step;
						pn_reg <= pn_reg + 5'h1;
					end else begin
						st_reg <= ptt_pkg::ST_FRAC;
					end
				end
				ptt_pkg::ST_FRAC: begin
					pw_reg <= pw_fr;
					st_reg <= ptt_pkg::ST_TIME;
					dq_reg <= 32'h0;
					dr_reg <= 32'h0;
					dcnt_reg <= 6'h0;
				end
				ptt_pkg::ST_TIME: begin
					if (dcnt_reg == 6'h0 && dnum_reg == 32'h0 && dq_reg == 32'h0) begin
						dnum_reg <= t_num;
						dden_reg <= over ? den_over : den_under;
					end
					dnum_reg <= (dcnt_reg == 6'h0) ? t_num << 1 : dnum_reg << 1;
					dden_reg <= over ? den_over : den_under;
					dr_reg <= (dcnt_reg == 6'h0) ? {31'h0, t_num[31]} - 32'h0 : d_rem;
					dq_reg <= d_quo;
					dcnt_reg <= dcnt_reg + 6'h1;
					if (d_last) st_reg <= ptt_pkg::ST_EVAL;
				end
				ptt_pkg::ST_EVAL: st_reg <= ptt_pkg::ST_IDLE;
				default: st_reg <= ptt_pkg::ST_IDLE;
			endcase
		end
	end

	// Inverse delay result, clamped to the longest settable time.
	wire [31:0] t_inv = !den_ok ? ptt_pkg::MAX_STEPS :
		(d_quo > ptt_pkg::MAX_STEPS) ? ptt_pkg::MAX_STEPS : d_quo;
	wire eval = st_reg == ptt_pkg::ST_EVAL;
	wire [63:0] ratio_m = 64'(rq_reg) * 64'(ptt_pkg::PCT_FULL);

	// Timer state and information values, updated once per cycle.
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			start_reg <= 1'b0;
			trip_reg <= 1'b0;
			blocked_reg <= 1'b0;
			pick_reg <= 1'b0;
			rel_reg <= 1'b0;
			opc_reg <= 32'h0;
			relc_reg <= 32'h0;
			expect_reg <= ptt_pkg::RST_DTDLY;
			remain_reg <= 32'h0;
			ratio_reg <= 32'h0;
		end else begin
			if (st_reg == ptt_pkg::ST_TIME && d_last) begin
				expect_reg <= inv_mode ? t_inv : dtdly_reg;
			end
			if (eval) begin
				pick_reg <= pick_next;
				blocked_reg <= pick_next & blk_s_reg;
				start_reg <= start_n;
				trip_reg <= trip_n;
				rel_reg <= rel_n;
				opc_reg <= opc_n;
				relc_reg <= relcnt_n;
				remain_reg <= (start_n | rel_n) ? delay - opc_n : delay;
				ratio_reg <= 32'(ratio_m >> 10);
			end
		end
	end

	// Blocking events carry the voltage and the fault direction.
	// blocking events
	wire blk_rise = eval & pick_next & blk_s_reg & ~blocked_reg;
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			disp_event_o <= 1'b0;
			blk_event_o <= 1'b0;
			blk_voltage_o <= '0;
			blk_over_o <= 1'b0;
		end else begin
			disp_event_o <= blk_rise;
			blk_event_o <= blk_rise;
			if (blk_rise) begin
				blk_voltage_o <= VW'(um_reg);
				blk_over_o <= over;
			end
		end
	end

	assign start_o = start_reg;
	assign trip_o = trip_reg;
	assign blocked_o = blocked_reg;

	a_start_unblocked: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		$rose(start_reg) |-> $past(eff) && $past(eval))
		else $error("START rose without unblocked pick-up");
	a_blocked_no_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		blocked_reg |-> !start_reg && !$rose(trip_reg))
		else $error("START or TRIP while blocked");
	a_block_clears_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		eval && blk_s_reg |=> !start_reg)
		else $error("START kept under blocking");
	a_block_event: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		$rose(blocked_reg) |-> blk_event_o && disp_event_o)
		else $error("blocking event missing");
	a_instant_trip: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		eval && eff && !inv_mode && dtdly_reg == 32'h0 |=> trip_reg && start_reg)
		else $error("instant mode did not trip with START");
	a_fixed_trip: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		$rose(trip_reg) && !inv_mode |-> opc_reg == $past(opc_reg) + 32'h1 && $past(opc_reg) >= dtdly_reg)
		else $error("fixed delay trip at wrong count");
	a_release_immediate: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		eval && !eff && !rel_on |=> !start_reg)
		else $error("START held with delayed release off");
	a_counter_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		eval && !eff && !rst_on |=> opc_reg == 32'h0)
		else $error("counter not cleared on pick-up reset");
	a_no_trip_release: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		eval && !eff |=> !trip_reg)
		else $error("TRIP without active pick-up");
endmodule : ptt_trip_timer
